// [design/cssc_pkg.sv]
// ----------------------------------------------------------------------------
// Shared constants for the parameter-set control block
// ----------------------------------------------------------------------------
`default_nettype none
package cssc_pkg;

    // Register field widths
    localparam int unsigned CSSC_ADDR_W = 5;
    localparam int unsigned CSSC_DATA_W = 8;
    localparam int unsigned CSSC_NUM_PARAMS = 5;
    localparam int unsigned CSSC_NUM_SETS = 2;

    // Register indices on the serial bus
    localparam logic [4:0] CSSC_ADDR_CTRL = 5'h00;
    localparam logic [4:0] CSSC_ADDR_SET1_BASE = 5'h01;
    localparam logic [4:0] CSSC_ADDR_SET2_BASE = 5'h06;
    localparam logic [4:0] CSSC_ADDR_STATUS = 5'h0B;

    // Control register field positions
    localparam int unsigned CSSC_CTRL_SEL_BIT = 0;
    localparam int unsigned CSSC_CTRL_PIN_EN_BIT = 1;

    // Status register field positions
    localparam int unsigned CSSC_STAT_SEL_BIT = 0;
    localparam int unsigned CSSC_STAT_TX_BIT = 1;

    // Parameter slot order within a set
    localparam int unsigned CSSC_P_MODE = 0;
    localparam int unsigned CSSC_P_POWER = 1;
    localparam int unsigned CSSC_P_RMODE = 2;
    localparam int unsigned CSSC_P_DELAY = 3;
    localparam int unsigned CSSC_P_FREQ = 4;

    // Operating mode code meaning transmitter
    localparam logic [7:0] CSSC_MODE_TX = 8'h03;

    // Values after reset
    localparam logic CSSC_RST_SEL = 1'b0;
    localparam logic CSSC_RST_PIN_EN = 1'b0;
    localparam logic [7:0] CSSC_RST_PARAM = 8'h00;

    // Frame layout: one direction bit, address bits, data bits
    localparam logic [3:0] CSSC_ADDR_BITS = 4'h5;
    localparam logic [3:0] CSSC_DATA_BITS = 4'h8;

    // Bus frame states
    typedef enum logic [1:0] {
        CSSC_ST_IDLE = 2'b00,
        CSSC_ST_ADDR = 2'b01,
        CSSC_ST_DATA = 2'b10,
        CSSC_ST_DONE = 2'b11
    } cssc_state_t;

endpackage
`default_nettype wire

// [design/cssc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module cssc_top
    import cssc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Serial bus
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic bus_en_n_in,
    output logic so_out,
    // Set-select pin
    input wire logic set_sel_pin_in,
    output logic set_sel_pin_out,
    output logic set_sel_pin_oe_out,
    // Active parameters
    output logic [7:0] operating_mode_out,
    output logic [7:0] output_power_out,
    output logic [7:0] receiver_mode_out,
    output logic [7:0] data_delay_out,
    output logic [7:0] carrier_frequency_out,
    output logic active_set_out
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic [3:0] raw_in;
    logic [3:0] sync_meta;
    logic [3:0] sync_q;
    logic sck_d;

    // Bit 0 clock, 1 data, 2 enable, 3 select pin
    assign raw_in = {set_sel_pin_in, bus_en_n_in, si_in, sck_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            // Two flops per pin; enable idles high so no false start follows reset
            always_ff @(posedge mclk_in) begin
                if (!rst_n_in) begin
                    sync_meta[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                    sync_q[gi] <= (gi == 2) ? 1'b1 : 1'b0;
                end else begin
                    sync_meta[gi] <= raw_in[gi];
                    sync_q[gi] <= sync_meta[gi];
                end
            end
        end
    endgenerate

    // Delayed serial clock for edge detection; resets to the idle low level
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sync_q[0];
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic si_s;
    logic bus_en_n_s;
    logic pin_s;

    // Edges of the serial clock time every bit
    assign sck_rise = sync_q[0] & ~sck_d;
    assign sck_fall = ~sync_q[0] & sck_d;
    assign si_s = sync_q[1];
    assign bus_en_n_s = sync_q[2];
    assign pin_s = sync_q[3];

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic set_select_bit;
    logic pin_select_enable;
    logic [7:0] dual_parameter_sets [CSSC_NUM_SETS][CSSC_NUM_PARAMS];
    logic eff_sel;
    logic tx_mode;

    // ------------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------------
    cssc_state_t state;
    cssc_state_t next_state;
    logic [3:0] bit_cnt;
    logic rd_flag;
    logic [4:0] addr_sr;
    logic [7:0] data_sr;
    logic [7:0] rd_sr;
    logic [7:0] rd_data;
    logic wr_strobe;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;

    // Read mux for the addressed register; unmapped reads give zero
    always_comb begin
        rd_data = 8'h00;
        if (addr_sr == CSSC_ADDR_CTRL) begin
            rd_data[CSSC_CTRL_SEL_BIT] = set_select_bit;
            rd_data[CSSC_CTRL_PIN_EN_BIT] = pin_select_enable;
        end else if (addr_sr == CSSC_ADDR_STATUS) begin
            rd_data[CSSC_STAT_SEL_BIT] = eff_sel;
            rd_data[CSSC_STAT_TX_BIT] = tx_mode;
        end else begin
            for (int s = 0; s < CSSC_NUM_SETS; s++) begin
                for (int p = 0; p < CSSC_NUM_PARAMS; p++) begin
                    if (addr_sr == CSSC_ADDR_SET1_BASE + 5'(s * CSSC_NUM_PARAMS + p)) begin
                        rd_data = dual_parameter_sets[s][p];
                    end
                end
            end
        end
    end

    // Next frame state; enable high always returns to idle
    always_comb begin
        next_state = state;
        if (bus_en_n_s) begin
            next_state = CSSC_ST_IDLE;
        end else if (sck_rise) begin
            case (state)
                CSSC_ST_IDLE: next_state = CSSC_ST_ADDR;
                CSSC_ST_ADDR: begin
                    if (bit_cnt == CSSC_ADDR_BITS - 4'h1) begin
                        next_state = CSSC_ST_DATA;
                    end
                end
                CSSC_ST_DATA: begin
                    if (bit_cnt == CSSC_DATA_BITS - 4'h1) begin
                        next_state = CSSC_ST_DONE;
                    end
                end
                CSSC_ST_DONE: next_state = CSSC_ST_DONE;
                default: next_state = CSSC_ST_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= CSSC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit counter, direction and shift registers on serial clock rises
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            bit_cnt <= 4'h0;
            rd_flag <= 1'b0;
            addr_sr <= 5'h00;
            data_sr <= 8'h00;
        end else if (bus_en_n_s) begin
            bit_cnt <= 4'h0;
        end else if (sck_rise) begin
            case (state)
                CSSC_ST_IDLE: begin
                    rd_flag <= si_s;
                    bit_cnt <= 4'h0;
                end
                CSSC_ST_ADDR: begin
                    addr_sr <= {addr_sr[3:0], si_s};
                    bit_cnt <= (bit_cnt == CSSC_ADDR_BITS - 4'h1) ? 4'h0 : bit_cnt + 4'h1;
                end
                CSSC_ST_DATA: begin
                    data_sr <= {data_sr[6:0], si_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                default: bit_cnt <= bit_cnt;
            endcase
        end
    end

    // Write commits on the last data bit of a write frame under enable
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            wr_strobe <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 8'h00;
        end else begin
            wr_strobe <= !bus_en_n_s && sck_rise && state == CSSC_ST_DATA && !rd_flag
                && bit_cnt == CSSC_DATA_BITS - 4'h1;
            wr_addr <= addr_sr;
            wr_data <= {data_sr[6:0], si_s};
        end
    end

    // Read data loads after the address and leaves on falling clock edges
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rd_sr <= 8'h00;
            so_out <= 1'b0;
        end else if (bus_en_n_s) begin
            so_out <= 1'b0;
        end else if (state == CSSC_ST_ADDR && next_state == CSSC_ST_DATA) begin
            rd_sr <= 8'h00;
        end else if (state == CSSC_ST_DATA && rd_flag && sck_fall && bit_cnt == 4'h0
            && rd_sr == 8'h00 && so_out == 1'b0) begin
            so_out <= rd_data[7];
            rd_sr <= {rd_data[6:0], 1'b1};
        end else if (state == CSSC_ST_DATA && rd_flag && sck_fall) begin
            so_out <= rd_sr[7];
            rd_sr <= {rd_sr[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // Control bits written over the bus
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            set_select_bit <= CSSC_RST_SEL;
            pin_select_enable <= CSSC_RST_PIN_EN;
        end else if (wr_strobe && wr_addr == CSSC_ADDR_CTRL) begin
            set_select_bit <= wr_data[CSSC_CTRL_SEL_BIT];
            pin_select_enable <= wr_data[CSSC_CTRL_PIN_EN_BIT];
        end
    end

    // Both parameter sets
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < CSSC_NUM_SETS; s++) begin
                for (int p = 0; p < CSSC_NUM_PARAMS; p++) begin
                    dual_parameter_sets[s][p] <= CSSC_RST_PARAM;
                end
            end
        end else if (wr_strobe) begin
            for (int s = 0; s < CSSC_NUM_SETS; s++) begin
                for (int p = 0; p < CSSC_NUM_PARAMS; p++) begin
                    if (wr_addr == CSSC_ADDR_SET1_BASE + 5'(s * CSSC_NUM_PARAMS + p)) begin
                        dual_parameter_sets[s][p] <= wr_data;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Set selection and select pin
    // ------------------------------------------------------------------------
    // Pin level rules when enabled, else the select bit
    assign eff_sel = pin_select_enable ? pin_s : set_select_bit;
    assign tx_mode = (operating_mode_out == CSSC_MODE_TX);

    // Whole set is copied in one edge so no mixture is ever visible
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            active_set_out <= 1'b0;
            operating_mode_out <= CSSC_RST_PARAM;
            output_power_out <= CSSC_RST_PARAM;
            receiver_mode_out <= CSSC_RST_PARAM;
            data_delay_out <= CSSC_RST_PARAM;
            carrier_frequency_out <= CSSC_RST_PARAM;
        end else begin
            active_set_out <= eff_sel;
            operating_mode_out <= dual_parameter_sets[eff_sel][CSSC_P_MODE];
            output_power_out <= dual_parameter_sets[eff_sel][CSSC_P_POWER];
            receiver_mode_out <= dual_parameter_sets[eff_sel][CSSC_P_RMODE];
            data_delay_out <= dual_parameter_sets[eff_sel][CSSC_P_DELAY];
            carrier_frequency_out <= dual_parameter_sets[eff_sel][CSSC_P_FREQ];
        end
    end

    // Select pin drives the transmit flag while pin select is off
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            set_sel_pin_oe_out <= 1'b1;
            set_sel_pin_out <= 1'b0;
        end else begin
            set_sel_pin_oe_out <= ~pin_select_enable;
            set_sel_pin_out <= ~pin_select_enable & tx_mode;
        end
    end

endmodule
`default_nettype wire

// [test/cssc_top_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module cssc_top_properties
    import cssc_pkg::*;
(
    // Clock, reset and serial bus
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic bus_en_n_in,
    input wire logic so_out,
    // Select pin
    input wire logic set_sel_pin_in,
    input wire logic set_sel_pin_out,
    input wire logic set_sel_pin_oe_out,
    // Active set
    input wire logic [7:0] operating_mode_out,
    input wire logic [7:0] output_power_out,
    input wire logic [7:0] receiver_mode_out,
    input wire logic [7:0] data_delay_out,
    input wire logic [7:0] carrier_frequency_out,
    input wire logic active_set_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // All five active parameters as one word
    logic [39:0] prm;
    assign prm = {operating_mode_out, output_power_out, receiver_mode_out,
                  data_delay_out, carrier_frequency_out};
    // ----
    // Sequences
    // ----
    sequence s_pin_hi; (!set_sel_pin_oe_out && set_sel_pin_in)[*5]; endsequence
    sequence s_pin_lo; (!set_sel_pin_oe_out && !set_sel_pin_in)[*5]; endsequence
    sequence s_quiet; bus_en_n_in[*8] ##0 $stable(active_set_out); endsequence
    sequence s_tx; (set_sel_pin_oe_out && operating_mode_out == CSSC_MODE_TX)[*3]; endsequence
    sequence s_no_tx; (set_sel_pin_oe_out && operating_mode_out != CSSC_MODE_TX)[*3]; endsequence
    // ----
    // Assertions
    // ----
    chk_tx_flag_high: assert property (s_tx |-> set_sel_pin_out)
        else $error("select pin not high in transmit mode");
    chk_tx_flag_low: assert property (s_no_tx |-> !set_sel_pin_out)
        else $error("select pin high outside transmit mode");
    chk_pin_flag_off: assert property ((!set_sel_pin_oe_out)[*3] |-> !set_sel_pin_out)
        else $error("select pin output active in pin mode");
    chk_pin_picks_two: assert property (s_pin_hi |-> active_set_out)
        else $error("high select pin did not pick set two");
    chk_pin_picks_one: assert property (s_pin_lo |-> !active_set_out)
        else $error("low select pin did not pick set one");
    chk_sets_not_mixed: assert property (s_quiet |-> $stable(prm))
        else $error("parameters moved without a set change");
    chk_so_idle_low: assert property (bus_en_n_in[*6] |-> !so_out)
        else $error("data out active while bus disabled");
    chk_so_shift_fall: assert property ((sck_in && !bus_en_n_in)[*3] |-> $stable(so_out))
        else $error("data out moved while serial clock high");
    chk_reset_values: assert property ($rose(rst_n_in) |->
        prm == 40'h0 && !active_set_out && set_sel_pin_oe_out && !so_out)
        else $error("outputs not at reset values");
endmodule
bind cssc_top cssc_top_properties u_chk (.mclk_in, .rst_n_in, .sck_in, .si_in,
    .bus_en_n_in, .so_out, .set_sel_pin_in, .set_sel_pin_out, .set_sel_pin_oe_out,
    .operating_mode_out, .output_power_out, .receiver_mode_out, .data_delay_out,
    .carrier_frequency_out, .active_set_out);
`default_nettype wire

// [test/cssc_mcu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cssc_mcu_model (
    // Clock
    input wire logic mclk_in,
    // Serial bus
    input wire logic so_in,
    output logic sck_out,
    output logic si_out,
    output logic bus_en_n_out
);
    // Idle bus: clock low, enable high
    initial begin
        sck_out = 1'b0;
        si_out = 1'b0;
        bus_en_n_out = 1'b1;
    end
    // One 14-bit frame at an 80 ns serial clock; q collects data out
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                        input logic en, output logic [7:0] q);
        logic [13:0] f;
        f = {rd, a, d};
        @(negedge mclk_in);
        bus_en_n_out = ~en;
        for (int i = 13; i >= 0; i--) begin
            si_out = (rd && i < 8) ? ~si_out : f[i];
            repeat (4) @(negedge mclk_in);
            sck_out = 1'b1;
            repeat (4) @(negedge mclk_in);
            if (i < 8) q[i] = so_in;
            sck_out = 1'b0;
        end
        repeat (2) @(negedge mclk_in);
        bus_en_n_out = 1'b1;
        si_out = ~si_out;
        repeat (12) @(negedge mclk_in);
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cssc_pkg::*;
    // ----
    // Signals and model state
    // ----
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pin_drv = 1'b0;
    logic sck, si, en_n, so, pin_out, pin_oe, act;
    logic [7:0] mode, pwr, rmd, dly, frq, q, v;
    int failures = 0;
    int tests_run = 0;
    int m[0:10];
    // Wire level of the select pin
    wire logic pin_w = (pin_oe === 1'b1) ? pin_out : pin_drv;
    always #5 mclk_in = ~mclk_in;
    cssc_top u_cssc_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sck_in(sck),
        .si_in(si), .bus_en_n_in(en_n), .so_out(so), .set_sel_pin_in(pin_w),
        .set_sel_pin_out(pin_out), .set_sel_pin_oe_out(pin_oe),
        .operating_mode_out(mode), .output_power_out(pwr), .receiver_mode_out(rmd),
        .data_delay_out(dly), .carrier_frequency_out(frq), .active_set_out(act));
    cssc_mcu_model u_cssc_mcu_model (.mclk_in(mclk_in), .so_in(so), .sck_out(sck),
        .si_out(si), .bus_en_n_out(en_n));
    // Effective selection and expected register contents
    function automatic logic sel_f();
        return m[0][1] ? pin_drv : m[0][0];
    endfunction
    function automatic logic [7:0] reg_f(int a);
        logic b;
        b = sel_f();
        if (a <= 10) return 8'(m[a]);
        if (a == 11) return {6'h00, 8'(m[b ? 6 : 1]) == CSSC_MODE_TX, b};
        return 8'h00;
    endfunction
    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_outs();
        int b;
        b = sel_f() ? 6 : 1;
        cmp(mode, 8'(m[b]));
        cmp(pwr, 8'(m[b + 1]));
        cmp(rmd, 8'(m[b + 2]));
        cmp(dly, 8'(m[b + 3]));
        cmp(frq, 8'(m[b + 4]));
        cmp({7'h00, act}, {7'h00, sel_f()});
        cmp({7'h00, pin_oe}, {7'h00, !m[0][1]});
        cmp({7'h00, pin_out}, {7'h00, !m[0][1] && 8'(m[b]) == CSSC_MODE_TX});
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] d);
        u_cssc_mcu_model.xfer(1'b0, a, d, 1'b1, q);
        if (a <= 5'h0A) m[a] = (a == 5'h00) ? int'(d & 8'h03) : int'(d);
        check_outs();
    endtask
    task automatic rd(logic [4:0] a);
        u_cssc_mcu_model.xfer(1'b1, a, 8'h00, 1'b1, q);
        cmp(q, reg_f(int'(a)));
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog against a hung bus
    initial begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        tally_and_finish();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'he069));
        foreach (m[i]) m[i] = 0;
        repeat (8) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        check_outs();
        // Fill both sets; set one runs in transmit mode
        for (int a = 1; a <= 10; a++) begin
            v = (a == 1) ? CSSC_MODE_TX : 8'($urandom_range(4, 255));
            wr(5'(a), v);
        end
        for (int a = 0; a <= 12; a++) rd((a == 12) ? 5'h1F : 5'(a));
        wr(5'h0B, 8'hFF);
        wr(5'h00, 8'h01);
        rd(5'h0B);
        // Frame with enable left high must be ignored
        u_cssc_mcu_model.xfer(1'b0, 5'h06, 8'h03, 1'b0, q);
        check_outs();
        // Pin mode with the select bit both ways
        for (int c = 2; c <= 3; c++) begin
            wr(5'h00, 8'(c));
            for (int p = 1; p >= 0; p--) begin
                pin_drv = p[0];
                repeat (6) @(negedge mclk_in);
                check_outs();
                rd(5'h0B);
            end
        end
        wr(5'h00, 8'h00);
        wr(5'h01, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
